/* File: rtl/cstin_core.sv */
/*
 Core processing-state machine with table lookup, frame link/release and
 pipeline synchronisation. Assumes the surrounding pipeline issues one
 instruction at a time and reports completion, bus errors and exceptions.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cstin_cfg.svh"
module cstin_core (
   input  wire logic                    core_clk,       // 100 MHz clock
   input  wire logic                    reset_n,        // Sync reset, low
   input  wire logic                    issueValid,     // Instruction offered
   input  wire cstin_pkg::cstin_issue_t issue,          // Instruction bundle
   output logic                         issueReady,     // Instruction taken
   input  wire logic                    pipeIdle,       // Earlier instrs done
   input  wire logic                    memSp,          // Supervisor stack on
   input  wire logic [31:0]             spIn,           // Stack pointer value
   input  wire logic [31:0]             popData,        // Word read at SP
   input  wire logic                    excReq,         // Exception pending
   input  wire logic                    excIsWake,      // Trace/int/reset exc
   input  wire logic                    handlerStart,   // Handler 1st instr
   input  wire logic                    busErr,         // Bus error seen
   input  wire logic                    addrErr,        // Address error made
   input  wire logic                    dbgEnter,       // Enter background
   input  wire logic                    dbgExit,        // Leave background
   output logic                         resValid,       // Result pulse
   output cstin_pkg::cstin_result_t     result,         // Result bundle
   output logic                         busEnable,      // Bus cycles allowed
   output logic                         supervisorRef,  // Supervisor marking
   output logic                         useSupStack,    // Stack via SUPERVISOR_STACK_POINTER
   output cstin_pkg::cstin_state_t      procState       // Current state
);
   cstin_pkg::cstin_state_t state_q;
   cstin_pkg::cstin_state_t state_d;
   logic [31:0] tblValue;
   logic        isTbl;
   logic        take;
   logic        nopWait;

   // Interpolator on the byte-form operand fields
   cstin_interp uInterp (
      .entryA  (issue.entryA),
      .entryB  (issue.entryB),
      .frac    (issue.operand[`CSTIN_FRAC_HI:`CSTIN_FRAC_LO]),
      .roundEn (issue.op == cstin_pkg::OP_TBL_RND),
      .result  (tblValue)
   );

   // Offset bits pick which fetched pair the pipeline presents; the caller
   // fetches entries at operand[15:8] and the next one
   assign isTbl = (issue.op == cstin_pkg::OP_TBL_RND) ||
                  (issue.op == cstin_pkg::OP_TBL_UNRND);
   // No-op is held back until the pipeline has drained
   assign nopWait = (issue.op == cstin_pkg::OP_NOP) && !pipeIdle;
   assign issueReady = (state_q == cstin_pkg::ST_NORMAL) && !nopWait && !excReq;
   assign take = issueValid && issueReady;

   // State transitions
   always_comb begin
      state_d = state_q;
      case (state_q)
         cstin_pkg::ST_NORMAL: begin
            if (excReq) begin
               state_d = cstin_pkg::ST_EXCEPTION;
            end else if (dbgEnter) begin
               state_d = cstin_pkg::ST_BACKGROUND;
            end else if (take && issue.op == cstin_pkg::OP_STOP) begin
               state_d = cstin_pkg::ST_STOPPED;
            end
         end
         cstin_pkg::ST_STOPPED: begin
            // Only trace, interrupt or reset exceptions wake the core
            if (excReq && excIsWake) begin
               state_d = cstin_pkg::ST_EXCEPTION;
            end
         end
         cstin_pkg::ST_BACKGROUND: begin
            if (dbgExit) begin
               state_d = cstin_pkg::ST_NORMAL;
            end
         end
         cstin_pkg::ST_EXCEPTION: begin
            // Double fault wins over handler start
            if (busErr || addrErr) begin
               state_d = cstin_pkg::ST_HALTED;
            end else if (handlerStart) begin
               state_d = cstin_pkg::ST_NORMAL;
            end
         end
         cstin_pkg::ST_HALTED: begin
            state_d = cstin_pkg::ST_HALTED;
         end
         default: begin
            state_d = cstin_pkg::ST_HALTED;
         end
      endcase
   end

   // State register; only reset leaves halted
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_q <= cstin_pkg::cstin_state_t'(`CSTIN_RESET_STATE);
      end else begin
         state_q <= state_d;
      end
   end

   // Results for table and frame instructions, registered
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         resValid <= 1'b0;
         result   <= '0;
      end else begin
         resValid <= take && (isTbl || issue.op == cstin_pkg::OP_LINK ||
                              issue.op == cstin_pkg::OP_RELEASE);
         if (take && isTbl) begin
            result.value <= tblValue;
         end else if (take && issue.op == cstin_pkg::OP_LINK) begin
            // Push register at SP-4, register takes that slot, then reserve
            result.pushAddr <= spIn - `CSTIN_WORD_BYTES;
            result.pushData <= issue.operand;
            result.value    <= spIn - `CSTIN_WORD_BYTES;
            result.sp       <= spIn - `CSTIN_WORD_BYTES + issue.disp;
         end else if (take && issue.op == cstin_pkg::OP_RELEASE) begin
            // SP from register, pop stored link, step past it
            result.value <= popData;
            result.sp    <= issue.operand + `CSTIN_WORD_BYTES;
         end
      end
   end

   // Bus and privilege marking follow the state
   assign busEnable     = (state_q == cstin_pkg::ST_NORMAL) ||
                          (state_q == cstin_pkg::ST_EXCEPTION);
   assign supervisorRef = (state_q == cstin_pkg::ST_EXCEPTION);
   assign useSupStack   = (state_q == cstin_pkg::ST_EXCEPTION) || memSp;
   assign procState     = state_q;

   // Checks, masked in reset since the state is rebuilt on the reset edge
   // Steps of the stop and double-fault behaviours, each named once and used by one check below
   sequence seqStopTaken;
      state_q == cstin_pkg::ST_NORMAL && !excReq && !dbgEnter && take &&
      issue.op == cstin_pkg::OP_STOP;
   endsequence
   sequence seqStoppedQuiet;
      state_q == cstin_pkg::ST_STOPPED && !busEnable;
   endsequence
   sequence seqExcFault;
      state_q == cstin_pkg::ST_EXCEPTION && (busErr || addrErr);
   endsequence
   sequence seqHaltTwice;
      state_q == cstin_pkg::ST_HALTED ##1 state_q == cstin_pkg::ST_HALTED;
   endsequence

   // State machine: one state at a time, stop, wake and fault paths
   chk_one_state: assert property (@(posedge core_clk) disable iff (!reset_n)
      $onehot(state_q)) else $error("state not one-hot");
   chk_stop_enter: assert property (@(posedge core_clk) disable iff (!reset_n)
      seqStopTaken |=> seqStoppedQuiet) else $error("stop did not stop");
   chk_stop_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_q == cstin_pkg::ST_STOPPED && !(excReq && excIsWake)) |=>
      state_q == cstin_pkg::ST_STOPPED) else $error("stopped left early");
   chk_wake_exc: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_q == cstin_pkg::ST_STOPPED && excReq && excIsWake) |=>
      state_q == cstin_pkg::ST_EXCEPTION) else $error("wake missed");
   chk_double_halt: assert property (@(posedge core_clk) disable iff (!reset_n)
      seqExcFault |=> seqHaltTwice) else $error("double fault not halted");
   chk_halt_stay: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_q == cstin_pkg::ST_HALTED |=> state_q == cstin_pkg::ST_HALTED)
      else $error("halted core woke");
   chk_exc_end: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_q == cstin_pkg::ST_EXCEPTION && !busErr && !addrErr && handlerStart) |=>
      state_q == cstin_pkg::ST_NORMAL) else $error("exception did not end");
   chk_bg_apart: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_q == cstin_pkg::ST_BACKGROUND && !dbgExit) |=>
      state_q == cstin_pkg::ST_BACKGROUND) else $error("background left");

   // Outputs that follow the state; a halted or stopped core stays off the bus
   chk_halt_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_q == cstin_pkg::ST_HALTED |-> !busEnable && !issueReady)
      else $error("halted core active");
   chk_issue_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_q != cstin_pkg::ST_NORMAL |-> !issueReady) else $error("issued outside normal");
   chk_exc_super: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_q == cstin_pkg::ST_EXCEPTION |-> supervisorRef && useSupStack)
      else $error("exception not supervisor");
   chk_nop_sync: assert property (@(posedge core_clk) disable iff (!reset_n)
      (issueValid && issue.op == cstin_pkg::OP_NOP && !pipeIdle) |-> !issueReady)
      else $error("no-op issued early");

   // Results: one pulse per taken result instruction, frame arithmetic
   chk_res_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
      !(take && (isTbl || issue.op == cstin_pkg::OP_LINK ||
                 issue.op == cstin_pkg::OP_RELEASE)) |=> !resValid)
      else $error("spare result pulse");
   chk_tbl_whole: assert property (@(posedge core_clk) disable iff (!reset_n)
      (take && issue.op == cstin_pkg::OP_TBL_RND &&
       issue.operand[`CSTIN_FRAC_HI:`CSTIN_FRAC_LO] == '0) |=>
      result.value == $past(issue.entryA)) else $error("zero fraction moved entry");
   chk_link_frame: assert property (@(posedge core_clk) disable iff (!reset_n)
      (take && issue.op == cstin_pkg::OP_LINK) |=>
      resValid && result.value == $past(spIn) - `CSTIN_WORD_BYTES &&
      result.pushData == $past(issue.operand)) else $error("link wrong");
   chk_link_stack: assert property (@(posedge core_clk) disable iff (!reset_n)
      (take && issue.op == cstin_pkg::OP_LINK) |=>
      result.pushAddr == $past(spIn) - `CSTIN_WORD_BYTES &&
      result.sp == $past(spIn) - `CSTIN_WORD_BYTES + $past(issue.disp))
      else $error("link stack wrong");
   chk_release: assert property (@(posedge core_clk) disable iff (!reset_n)
      (take && issue.op == cstin_pkg::OP_RELEASE) |=>
      result.sp == $past(issue.operand) + `CSTIN_WORD_BYTES &&
      result.value == $past(popData)) else $error("release wrong");
endmodule // cstin_core
`default_nettype wire

/* File: pkg/cstin_cfg.svh */
/*
 Constants for the core state and table-interpolation block.
 Assumes inclusion by bare name from the package and rtl files.
*/
`ifndef CSTIN_CFG_SVH
`define CSTIN_CFG_SVH
`define CSTIN_ENTRY_HI      15
`define CSTIN_ENTRY_LO      8
`define CSTIN_FRAC_HI       7
`define CSTIN_FRAC_LO       0
`define CSTIN_FRAC_W        8
`define CSTIN_FRAC_HALF     8'h0080
`define CSTIN_WORD_BYTES    32'h0000_0004
`define CSTIN_RESET_STATE   5'h01
`endif

/* File: pkg/cstin_pkg.sv */
/*
 Types for the core state and table-interpolation block.
 Assumes cstin_cfg.svh is on the include path.
*/
`default_nettype none
`include "cstin_cfg.svh"
package cstin_pkg;
   // Processing states, one-hot
   typedef enum logic [4:0] {
      ST_NORMAL     = 5'b0_0001,
      ST_STOPPED    = 5'b0_0010,
      ST_BACKGROUND = 5'b0_0100,
      ST_EXCEPTION  = 5'b0_1000,
      ST_HALTED     = 5'b1_0000
   } cstin_state_t;

   // Instruction classes presented to the block
   typedef enum logic [2:0] {
      OP_NONE      = 3'h0,
      OP_TBL_RND   = 3'h1,
      OP_TBL_UNRND = 3'h2,
      OP_LINK      = 3'h3,
      OP_RELEASE   = 3'h4,
      OP_NOP       = 3'h5,
      OP_STOP      = 3'h6
   } cstin_op_t;

   // Instruction issue bundle
   typedef struct packed {
      cstin_op_t   op;
      logic [31:0] operand;   // Table operand or address register value
      logic [31:0] entryA;    // Table entry at offset (signed)
      logic [31:0] entryB;    // Next table entry (signed)
      logic [31:0] disp;      // Frame displacement (negative reserves)
   } cstin_issue_t;

   // Result bundle
   typedef struct packed {
      logic [31:0] value;     // Table result or new address register
      logic [31:0] sp;        // New stack pointer
      logic [31:0] pushAddr;  // Stack write address for frame link
      logic [31:0] pushData;  // Stack write data for frame link
   } cstin_result_t;
endpackage : cstin_pkg
`default_nettype wire

/* File: rtl/cstin_interp.sv */
/*
 Signed table interpolator: entry + frac*(next-entry)/256.
 Assumes entries already fetched; combinational, registered by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cstin_cfg.svh"
module cstin_interp (
   input  wire logic [31:0] entryA,    // Entry at offset
   input  wire logic [31:0] entryB,    // Next entry
   input  wire logic [7:0]  frac,      // Interpolation fraction
   input  wire logic        roundEn,   // High rounds, low keeps fraction
   output logic      [31:0] result     // Integer, or value with 8 fraction bits
);
   logic signed [41:0] diff;
   logic signed [41:0] scaled;
   logic signed [41:0] full;
   logic        [33:0] intPart;
   logic        [7:0]  fracPart;
   logic               up;

   // Work scaled by 256 so the fraction survives for the unrounded form
   always_comb begin
      diff     = 42'(signed'(entryB)) - 42'(signed'(entryA));
      scaled   = diff * signed'({34'h0_0000_0000, frac});
      full     = (42'(signed'(entryA)) <<< `CSTIN_FRAC_W) + scaled;
      intPart  = full[41:8];
      fracPart = full[7:0];
      // Halfway ties go to the even integer
      up = (fracPart > `CSTIN_FRAC_HALF) ||
           ((fracPart == `CSTIN_FRAC_HALF) && intPart[0]);
      if (roundEn) begin
         result = intPart[31:0] + {31'h0000_0000, up};
      end else begin
         result = full[31:0];
      end
   end
endmodule // cstin_interp
`default_nettype wire

/* File: sim/cstin_mem_model.sv */
/*
 Far-side model: stack memory read data and the pipeline-idle source.
 Assumes the bench kicks it to stand for earlier instructions in flight.
*/
`timescale 1ns/10ps
`default_nettype none
module cstin_mem_model (
   input  wire logic        core_clk,  // System clock
   input  wire logic        reset_n,   // Sync reset, low
   input  wire logic        readEn,    // Release on offer
   input  wire logic [31:0] addr,      // Read address
   input  wire logic [2:0]  kick,      // Cycles of earlier work
   output logic      [31:0] popData,   // Word at addr
   output logic             pipeIdle   // Earlier work complete
);
   logic [31:0] lastQ;
   logic [2:0]  busyQ;
   // Off-cycle shows the inverse of last cycle's word, so stale data comes back every second off-cycle
   assign popData  = readEn ? (32'hA5A5_0000 ^ addr) : ~lastQ;
   assign pipeIdle = (busyQ == 3'h0);
   // Busy countdown; a zero kick answers promptly
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         busyQ <= 3'h0;
         lastQ <= 32'h0000_0000;
      end else begin
         busyQ <= (kick != 3'h0) ? kick : busyQ - ((busyQ != 3'h0) ? 3'h1 : 3'h0);
         lastQ <= popData;
      end
   end
endmodule // cstin_mem_model
`default_nettype wire

/* File: sim/tb_top.sv */
/*
 Self-checking bench for cstin_core: lookups, frame ops, no-op, states.
 Assumes cstin_pkg is compiled first and the far-side model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic core_clk, reset_n, issueValid, issueReady, pipeIdle, memSp, resValid;
   logic excReq, excIsWake, handlerStart, busErr, addrErr, dbgEnter, dbgExit;
   logic busEnable, supervisorRef, useSupStack;
   logic [31:0] spIn, popData, r;
   logic [31:0] seed = 32'h0001_28B4;
   logic [2:0]  kick;
   cstin_pkg::cstin_issue_t  issue;
   cstin_pkg::cstin_result_t result, e, expQ[$];
   cstin_pkg::cstin_state_t  procState;
   int fullQ[$], f, k, bad_count, n_checks;
   logic [31:0] u1, u2;
   cstin_core uut (.core_clk(core_clk), .reset_n(reset_n), .issueValid(issueValid),
      .issue(issue), .issueReady(issueReady), .pipeIdle(pipeIdle), .memSp(memSp),
      .spIn(spIn), .popData(popData), .excReq(excReq), .excIsWake(excIsWake),
      .handlerStart(handlerStart), .busErr(busErr), .addrErr(addrErr),
      .dbgEnter(dbgEnter), .dbgExit(dbgExit), .resValid(resValid), .result(result),
      .busEnable(busEnable), .supervisorRef(supervisorRef),
      .useSupStack(useSupStack), .procState(procState));
   cstin_mem_model farSide (.core_clk(core_clk), .reset_n(reset_n),
      .readEn(issueValid && issue.op == cstin_pkg::OP_RELEASE),
      .addr(issue.operand), .kick(kick), .popData(popData), .pipeIdle(pipeIdle));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
      return seed;
   endfunction
   // Table contents the caller fetches; odd step makes 0x80 a halfway case
   function automatic logic [31:0] tbl(input logic [7:0] i);
      return {24'h0, i} * 32'h0000_0025 - 32'h0000_07D0;
   endfunction
   function automatic logic [31:0] interp(input logic [31:0] a, b, input logic [7:0] fr,
                                          input bit rd);
      longint x, q;
      x = longint'($signed(a)) * 256 + longint'(fr) * (longint'($signed(b)) - longint'($signed(a)));
      q = x >>> 8;
      if (rd && (x[7:0] > 8'h80 || (x[7:0] == 8'h80 && q[0]))) q = q + 1;
      return rd ? q[31:0] : x[31:0];
   endfunction
   task automatic chkVal(input string n, input logic [31:0] ex, input logic [31:0] s);
      n_checks++;
      if (s !== ex) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, ex, s);
      end
   endtask
   task automatic chkState(input cstin_pkg::cstin_state_t ex);
      chkVal("state", {27'h0, ex}, {27'h0, procState});
      chkVal("busEnable",
             {31'h0, ex inside {cstin_pkg::ST_NORMAL, cstin_pkg::ST_EXCEPTION}},
             {31'h0, busEnable});
      chkVal("supervisorRef",
             {31'h0, ex == cstin_pkg::ST_EXCEPTION}, {31'h0, supervisorRef});
      chkVal("useSupStack", {31'h0, ex == cstin_pkg::ST_EXCEPTION || memSp},
             {31'h0, useSupStack});
   endtask
   // Offer and hold until taken; left valid so requests can run back to back
   task automatic offer(input cstin_pkg::cstin_issue_t i);
      logic rdy;
      issue <= i;
      issueValid <= 1'b1;
      memSp <= seed[3];
      for (k = 0; k < 20; k++) begin
         @(negedge core_clk);
         rdy = issueReady;
         chkVal("ready", {31'h0, i.op != cstin_pkg::OP_NOP || pipeIdle}, {31'h0, rdy});
         @(posedge core_clk);
         if (rdy === 1'b1) break;
      end
      if (k == 20) chkVal("taken", 1, 0);
   endtask
   task automatic lookup(input cstin_pkg::cstin_op_t op, input logic [15:0] x,
                         input logic [31:0] a, b);
      cstin_pkg::cstin_result_t n;
      n = '{interp(a, b, x[7:0], op == cstin_pkg::OP_TBL_RND), 0, 0, 0};
      expQ.push_back(n);
      fullQ.push_back(0);
      offer('{op, {16'h0, x}, a, b, 32'h0});
   endtask
   // Pulse the event inputs for one cycle, then let the state settle
   task automatic ev(input logic [6:0] v);
      @(posedge core_clk);
      {excReq, excIsWake, handlerStart, busErr, addrErr, dbgEnter, dbgExit} <= v;
      @(posedge core_clk);
      {excReq, excIsWake, handlerStart, busErr, addrErr, dbgEnter, dbgExit} <= 7'h00;
      @(negedge core_clk);
   endtask
   task automatic pulseReset();
      @(posedge core_clk) reset_n <= 1'b0;
      @(posedge core_clk) reset_n <= 1'b1;
      @(negedge core_clk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Result watcher: oldest note against each result pulse
   always @(negedge core_clk) begin
      if (resValid === 1'b1) begin
         if (expQ.size() == 0) chkVal("spare result", 0, 1);
         else begin
            e = expQ.pop_front();
            f = fullQ.pop_front();
            chkVal("value", e.value, result.value);
            if (f > 0) chkVal("sp", e.sp, result.sp);
            if (f > 1) chkVal("pushAddr", e.pushAddr, result.pushAddr);
            if (f > 1) chkVal("pushData", e.pushData, result.pushData);
         end
      end
   end
   // Watchdog at 20,000 cycles, far beyond the hundred or so cycles the run needs
   initial begin
      #200_000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      reset_n = 1'b0;
      issueValid = 1'b0;
      issue = '0;
      {memSp, spIn, kick} = '0;
      {excReq, excIsWake, handlerStart, busErr, addrErr, dbgEnter, dbgExit} = 7'h00;
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk) chkState(cstin_pkg::ST_NORMAL);
      @(posedge core_clk);
      lookup(cstin_pkg::OP_TBL_RND, 16'h0BD0, 32'h0000_0050, 32'h0000_0040);
      lookup(cstin_pkg::OP_TBL_RND, 16'h0500, tbl(8'h05), tbl(8'h06));
      // Four halfway fractions first, then random offsets, both lookup kinds
      for (int j = 0; j < 40; j++) begin
         r = (j < 4) ? {16'h0, j[7:0], 8'h80} : rnd();
         lookup(j[0] ? cstin_pkg::OP_TBL_RND : cstin_pkg::OP_TBL_UNRND, r[15:0], tbl(r[15:8]),
                tbl(r[15:8] + 8'h01));
      end
      // Surface step: byte partials paired into one wider rounded lookup
      u1 = interp(tbl(8'h03), tbl(8'h04), 8'h40, 1'b0);
      u2 = interp(tbl(8'h09), tbl(8'h0A), 8'h40, 1'b0);
      lookup(cstin_pkg::OP_TBL_RND, 16'h00C0, u1, u2);
      // Link then release of the same frame, back to back
      for (int j = 0; j < 4; j++) begin
         r = {rnd() & 32'h00FF_FFFC};
         spIn <= r;
         e = '{r - 32'h4, r - 32'h4 - 32'h40, r - 32'h4, seed};
         expQ.push_back(e);
         fullQ.push_back(2);
         offer('{cstin_pkg::OP_LINK, seed, 32'h0, 32'h0, -32'h0000_0040});
         e = '{32'hA5A5_0000 ^ (r - 32'h4), r, 32'h0, 32'h0};
         expQ.push_back(e);
         fullQ.push_back(1);
         offer('{cstin_pkg::OP_RELEASE, r - 32'h4, 32'h0, 32'h0, 32'h0});
      end
      issueValid <= 1'b0;
      kick <= 3'h4;
      @(posedge core_clk) kick <= 3'h0;
      offer('{cstin_pkg::OP_NOP, 32'h0, 32'h0, 32'h0, 32'h0});
      offer('{cstin_pkg::OP_STOP, 32'h0, 32'h0, 32'h0, 32'h0});
      issueValid <= 1'b0;
      repeat (2) @(negedge core_clk);
      chkState(cstin_pkg::ST_STOPPED);
      ev(7'b100_0010);
      chkState(cstin_pkg::ST_STOPPED);
      ev(7'b110_0000);
      chkState(cstin_pkg::ST_EXCEPTION);
      ev(7'b001_0000);
      chkState(cstin_pkg::ST_NORMAL);
      ev(7'b100_0000);
      ev(7'b001_0100);
      chkState(cstin_pkg::ST_HALTED);
      ev(7'b111_0010);
      chkState(cstin_pkg::ST_HALTED);
      chkVal("ready", 0, {31'h0, issueReady});
      pulseReset();
      chkState(cstin_pkg::ST_NORMAL);
      ev(7'b100_0000);
      ev(7'b000_1000);
      chkState(cstin_pkg::ST_HALTED);
      pulseReset();
      ev(7'b000_0010);
      chkState(cstin_pkg::ST_BACKGROUND);
      ev(7'b000_0001);
      chkState(cstin_pkg::ST_NORMAL);
      repeat (3) @(negedge core_clk);
      chkVal("notes left", 0, expQ.size());
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
